// ---- logic/pilc_controller.sv ----
// Prioritised interrupt latch controller top with its register file
//
// Summary of operation
// - Nineteen sources, three levels shared by two
// - Four non-maskable sources, rest maskable and nested
// - Request event sets latch, latch requests core
// - Maskable needs master, own enable; line zero also its pin qualifier
// - Fixed hardware priority; soft trap first, then lowest latch
// - Reset FFFE; trap, bad opcode FFFC unlatched
// - Fetch trap uses latch 2, vector FFFA
// - Watchdog uses latch 3, vector FFF8
// - Line zero latch 4, FFF6, needs pin enable
// - Latches 5 to 12 vectors FFF4 to FFE6
// - Latch 13: receive or timer 2 by selector
// - Latch 14: line four or transmit
// - Latch 15: line five or converter done
// - Fetch trap interrupts only when action bit clear
// - Watchdog interrupts only when action bit clear
// - Accepted latch is cleared immediately
// - Reset forces every latch to zero
// - Latches at 3C/3D, cleared by writing zero
// - Writing one never sets a latch
// - Latch reads return current pending state
// - Accept stacks master enable then clears it
// - Master enable bit 0 at 3A, enables 3A/3B
`timescale 1ns/100ps
`default_nettype none
`include "pilc_regs.svh"
module pilc_controller
  import pilc_pkg::*;
(
  input  wire logic        sys_clk,            // 10 MHz system clock
  input  wire logic        resetn,             // Asynchronous reset, low
  // Register port of the core, byte wide
  input  wire logic  [7:0] regAddr,            // SFR byte address
  input  wire logic  [7:0] regWriteData,       // Store data
  input  wire logic        regWrite,           // Store strobe
  output logic       [7:0] regReadData,        // Load data
  // Hardware request events, one-cycle pulses
  input  wire logic        softwareTrap,       // Trap instruction
  input  wire logic        badOpcodeEvent,     // Undefined opcode
  input  wire logic        fetchTrapEvent,     // Fetch from bad area
  input  wire logic        watchdogEvent,      // Watchdog overflow
  input  wire logic        extLineZero,        // External line zero
  input  wire logic  [7:0] plainEvents,        // Latches 5..12
  input  wire logic        uartReceiveEvent,
  input  wire logic        timer2Event,
  input  wire logic        extLineFour,
  input  wire logic        uartTransmitEvent,
  input  wire logic        extLineFive,
  input  wire logic        converterDoneEvent,
  // Qualifiers owned by other blocks
  input  wire logic        lineZeroEnable,     // Pin function enable
  input  wire logic        trapActionChoice,   // 1 = reset request
  input  wire logic        watchdogActionChoice, // 1 = reset request
  // Core handshake
  output logic             intRequest,         // Acceptance request
  output logic      [15:0] intVector,          // Vector of the offer
  input  wire logic        intAccept,          // Core takes the offer
  input  wire logic        returnFromHandler,  // Restores master enable
  output logic             stackedMaster       // Value pushed on accept
);

  logic        rstSync1;       // Reset release stage one
  logic        rstn;           // Synchronised reset
  pilc_word_t  pendingFlag;    // Latch bits 2..15
  pilc_word_t  sourceEnable;   // Bit 0 master, 4..15 individual
  logic  [2:0] sharedLevelSelector;
  logic  [2:0] sharedRequest;
  pilc_word_t  requestEvent;   // Event per latch bit
  pilc_word_t  eligible;       // Latch may be offered
  logic        found;
  pilc_index_t winner;
  logic [15:0] pickVector;
  logic        softPending;    // Trap or bad opcode waiting
  logic        masterEnable;
  pilc_state_t state;
  pilc_state_t next_state;
  pilc_index_t offerIndex;     // Latch being offered
  logic        offerSoft;      // Offer is an unlatched source
  pilc_word_t  writeClear;     // Latch bits cleared by a store
  pilc_word_t  acceptClear;    // Latch bit cleared by acceptance

  assign masterEnable = sourceEnable[`PILC_MASTER_BIT];

  // Reset is released through two stages, asserted at once
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1 <= 1'b0;
      rstn     <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstn     <= rstSync1;
    end
  end

  // Shared levels pick one of two sources each
  pilc_source_mux u_mux (
    .uartReceiveEvent    (uartReceiveEvent),
    .timer2Event         (timer2Event),
    .extLineFour         (extLineFour),
    .uartTransmitEvent   (uartTransmitEvent),
    .extLineFive         (extLineFive),
    .converterDoneEvent  (converterDoneEvent),
    .sharedLevelSelector (sharedLevelSelector),
    .sharedRequest       (sharedRequest)
  );

  // Gather events; trap and watchdog only raise an interrupt when
  // their action choice says so, otherwise the reset path owns them
  always_comb begin
    requestEvent       = 16'h0000;
    requestEvent[`PILC_TRAP_BIT] = fetchTrapEvent &
                                   ~trapActionChoice;
    requestEvent[`PILC_WDOG_BIT] = watchdogEvent &
                                   ~watchdogActionChoice;
    requestEvent[`PILC_LINE0_BIT] = extLineZero;
    requestEvent[12:5] = plainEvents;
    requestEvent[15:13] = sharedRequest;
  end

  // Store clears: a zero bit at 3C/3D clears, a one does nothing
  always_comb begin
    writeClear = 16'h0000;
    if (regWrite && regAddr == `PILC_ADDR_LATCH_LOW) begin
      writeClear[7:0] = ~regWriteData;
    end else if (regWrite && regAddr == `PILC_ADDR_LATCH_HIGH) begin
      writeClear[15:8] = ~regWriteData;
    end
    acceptClear = 16'h0000;
    if (state == PILC_OFFER && intAccept && !offerSoft) begin
      acceptClear[offerIndex] = 1'b1;
    end
  end

  // Latches: a new event beats a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_latch
      if (g < `PILC_FIRST_LATCH) begin : g_none
        always_comb pendingFlag[g] = 1'b0;
      end else begin : g_bit
        always_ff @(posedge sys_clk or negedge rstn) begin
          if (!rstn) begin
            pendingFlag[g] <= 1'b0;
          end else if (requestEvent[g]) begin
            pendingFlag[g] <= 1'b1;
          end else if (writeClear[g] || acceptClear[g]) begin
            pendingFlag[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Non-maskable latches skip enables; maskable need master and own
  always_comb begin
    eligible = pendingFlag & sourceEnable & {16{masterEnable}};
    eligible[1:0] = 2'b00;
    eligible[`PILC_LINE0_BIT] = eligible[`PILC_LINE0_BIT] &
                                lineZeroEnable;
    eligible[`PILC_TRAP_BIT] = pendingFlag[`PILC_TRAP_BIT];
    eligible[`PILC_WDOG_BIT] = pendingFlag[`PILC_WDOG_BIT];
  end

  pilc_priority_pick u_pick (
    .eligible (eligible),
    .found    (found),
    .winner   (winner),
    .vector   (pickVector)
  );

  // Unlatched trap sources wait here until the core takes them
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      softPending <= 1'b0;
    end else if (softwareTrap || badOpcodeEvent) begin
      softPending <= 1'b1;
    end else if (state == PILC_OFFER && intAccept && offerSoft) begin
      softPending <= 1'b0;
    end
  end

  // Offer sequence toward the core
  always_comb begin
    next_state = state;
    case (state)
      PILC_IDLE: begin
        if (softPending || found) begin
          next_state = PILC_OFFER;
        end
      end
      PILC_OFFER: begin
        if (intAccept) begin
          next_state = PILC_TAKEN;
        end
      end
      PILC_TAKEN: begin
        next_state = PILC_IDLE;
      end
      default: begin
        next_state = PILC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= PILC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Offer is frozen while raised; the unlatched soft trap is taken
  // ahead of every latch, and the picker ranks latch 2 above latch 3
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      offerIndex <= 4'h0;
      offerSoft  <= 1'b0;
      intVector  <= `PILC_VEC_RESET;
    end else if (state == PILC_IDLE && softPending) begin
      offerSoft  <= 1'b1;
      offerIndex <= 4'h0;
      intVector  <= `PILC_VEC_SOFT;
    end else if (state == PILC_IDLE && found) begin
      offerSoft  <= 1'b0;
      offerIndex <= winner;
      intVector  <= pickVector;
    end
  end

  assign intRequest = (state == PILC_OFFER);

  // Enable register and stacked master enable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sourceEnable  <= `PILC_ENABLE_RESET;
      stackedMaster <= 1'b0;
    end else if (state == PILC_OFFER && intAccept) begin
      stackedMaster <= masterEnable;
      sourceEnable[`PILC_MASTER_BIT] <= 1'b0;
    end else if (returnFromHandler) begin
      sourceEnable[`PILC_MASTER_BIT] <= stackedMaster;
    end else if (regWrite && regAddr == `PILC_ADDR_ENABLE_LOW) begin
      sourceEnable[7:4] <= regWriteData[7:4];
      sourceEnable[`PILC_MASTER_BIT] <= regWriteData[0];
    end else if (regWrite && regAddr == `PILC_ADDR_ENABLE_HIGH) begin
      sourceEnable[15:8] <= regWriteData;
    end
  end

  // Shared-level selector
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sharedLevelSelector <= `PILC_SELECTOR_RESET;
    end else if (regWrite && regAddr == `PILC_ADDR_SELECTOR) begin
      sharedLevelSelector <= regWriteData[2:0];
    end
  end

  // Read data registered one cycle after the address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regReadData <= 8'h00;
    end else if (regAddr == `PILC_ADDR_LATCH_LOW) begin
      regReadData <= pendingFlag[7:0];
    end else if (regAddr == `PILC_ADDR_LATCH_HIGH) begin
      regReadData <= pendingFlag[15:8];
    end else if (regAddr == `PILC_ADDR_ENABLE_LOW) begin
      regReadData <= {sourceEnable[7:4], 3'h0, masterEnable};
    end else if (regAddr == `PILC_ADDR_ENABLE_HIGH) begin
      regReadData <= sourceEnable[15:8];
    end else if (regAddr == `PILC_ADDR_SELECTOR) begin
      regReadData <= {5'h00, sharedLevelSelector};
    end else begin
      regReadData <= 8'h00;
    end
  end

  // Checks
  AST_EVENT_SETS: assert property (@(posedge sys_clk)
    disable iff (!rstn) requestEvent[9] |=> pendingFlag[9])
    else $error("latch 9 not set by event");
  AST_MASK_BLOCKS: assert property (@(posedge sys_clk)
    disable iff (!rstn) (state == PILC_IDLE && !masterEnable &&
     !softPending && pendingFlag[3:2] == 2'b00) |=> state != PILC_OFFER)
    else $error("masked request offered");
  AST_ACCEPT_CLEARS: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    (intRequest && intAccept && !offerSoft &&
     !requestEvent[offerIndex]) |=> !pendingFlag[$past(offerIndex)])
    else $error("accepted latch not cleared");
  AST_ONE_NO_SET: assert property (@(posedge sys_clk)
    disable iff (!rstn) (regWrite && regAddr == `PILC_ADDR_LATCH_HIGH &&
     !pendingFlag[10] && !requestEvent[10]) |=> !pendingFlag[10])
    else $error("store set a latch");
  AST_MASTER_DROP: assert property (@(posedge sys_clk)
    disable iff (!rstn) (intRequest && intAccept) |=> !masterEnable &&
    stackedMaster == $past(masterEnable))
    else $error("master enable not stacked");
  AST_TRAP_VECTOR: assert property (@(posedge sys_clk)
    disable iff (!rstn) (intRequest && offerIndex == 4'h2 && !offerSoft)
    |-> intVector == 16'hFFFA)
    else $error("trap vector wrong");
  AST_WDOG_VECTOR: assert property (@(posedge sys_clk)
    disable iff (!rstn) (intRequest && offerIndex == 4'h3 && !offerSoft)
    |-> intVector == 16'hFFF8)
    else $error("watchdog vector wrong");
  AST_TRAP_GATED: assert property (@(posedge sys_clk)
    disable iff (!rstn) (trapActionChoice && !pendingFlag[2]) |=>
    !pendingFlag[2])
    else $error("trap latched while in reset mode");
  AST_SOFT_VECTOR: assert property (@(posedge sys_clk)
    disable iff (!rstn) (intRequest && offerSoft) |-> intVector == 16'hFFFC)
    else $error("soft trap vector wrong");
  AST_OFFER_HOLDS: assert property (@(posedge sys_clk)
    disable iff (!rstn) (intRequest && !intAccept) |=> intRequest &&
    $stable(intVector))
    else $error("offer dropped before accept");
  COV_ACCEPT: cover property (@(posedge sys_clk) disable iff (!rstn)
    intRequest && intAccept && !offerSoft);
  COV_SOFT: cover property (@(posedge sys_clk) disable iff (!rstn)
    intRequest && intAccept && offerSoft);
  COV_RETURN: cover property (@(posedge sys_clk) disable iff (!rstn)
    returnFromHandler && stackedMaster);
endmodule
`default_nettype wire

// ---- logic/pilc_regs.svh ----
// Register offsets, field positions, reset values and vectors of the interrupt latch controller
`ifndef PILC_REGS_SVH
`define PILC_REGS_SVH
`define PILC_ADDR_ENABLE_LOW   8'h3A
`define PILC_ADDR_ENABLE_HIGH  8'h3B
`define PILC_ADDR_LATCH_LOW    8'h3C
`define PILC_ADDR_LATCH_HIGH   8'h3D
`define PILC_ADDR_SELECTOR     8'h3E
`define PILC_MASTER_BIT        0
`define PILC_TRAP_BIT          2
`define PILC_WDOG_BIT          3
`define PILC_LINE0_BIT         4
`define PILC_SEL14_BIT         2
`define PILC_SEL15_BIT         1
`define PILC_SEL16_BIT         0
`define PILC_LATCH_RESET       16'h0000
`define PILC_ENABLE_RESET      16'h0000
`define PILC_SELECTOR_RESET    3'h0
`define PILC_VEC_RESET         16'hFFFE
`define PILC_VEC_SOFT          16'hFFFC
`define PILC_VEC_BASE          16'hFFFA
`define PILC_FIRST_LATCH       2
`define PILC_LAST_LATCH        15
`endif

// ---- logic/pilc_pkg.sv ----
// Types shared by the interrupt latch controller
package pilc_pkg;
  typedef logic [15:0] pilc_word_t;   // Latch or enable image
  typedef logic [3:0]  pilc_index_t;  // Latch bit index
  typedef enum logic [1:0] {
    PILC_IDLE  = 2'b00,  // Nothing being serviced
    PILC_OFFER = 2'b01,  // Request raised toward the core
    PILC_TAKEN = 2'b11   // Acceptance being finished
  } pilc_state_t;
endpackage

// ---- logic/pilc_source_mux.sv ----
// Routes shared-level sources onto their latch request lines
`timescale 1ns/100ps
`default_nettype none
`include "pilc_regs.svh"
module pilc_source_mux
  import pilc_pkg::*;
(
  input  wire logic       uartReceiveEvent,
  input  wire logic       timer2Event,
  input  wire logic       extLineFour,
  input  wire logic       uartTransmitEvent,
  input  wire logic       extLineFive,
  input  wire logic       converterDoneEvent,
  input  wire logic [2:0] sharedLevelSelector,
  output logic      [2:0] sharedRequest       // Bits 0..2 feed latches 13..15
);
  // Unselected sources are dropped, never held
  always_comb begin
    sharedRequest[0] = sharedLevelSelector[`PILC_SEL14_BIT] ?
                       timer2Event : uartReceiveEvent;
    sharedRequest[1] = sharedLevelSelector[`PILC_SEL15_BIT] ?
                       uartTransmitEvent : extLineFour;
    sharedRequest[2] = sharedLevelSelector[`PILC_SEL16_BIT] ?
                       converterDoneEvent : extLineFive;
  end
endmodule
`default_nettype wire

// ---- logic/pilc_priority_pick.sv ----
// Fixed priority picker: lowest latch index wins, with its vector
`timescale 1ns/100ps
`default_nettype none
`include "pilc_regs.svh"
module pilc_priority_pick
  import pilc_pkg::*;
(
  input  wire logic [15:0] eligible,   // Pending and enabled latches
  output logic             found,      // Any eligible latch
  output pilc_index_t      winner,     // Chosen latch index
  output logic      [15:0] vector      // Its vector address
);
  // Scan from the top down so the smallest index is the last to win
  always_comb begin
    found  = 1'b0;
    winner = 4'h0;
    for (int i = `PILC_LAST_LATCH; i >= `PILC_FIRST_LATCH; i--) begin
      if (eligible[i]) begin
        found  = 1'b1;
        winner = 4'(i);
      end
    end
    // Vectors step down by two per latch from the trap vector
    vector = 16'(`PILC_VEC_BASE - 16'({winner, 1'b0} - 5'h04));
  end
endmodule
`default_nettype wire

// ---- tb/pilc_core_model.sv ----
// Behavioural CPU core that takes offered interrupts and records vectors
`timescale 1ns/100ps
`default_nettype none
module pilc_core_model (
  input  wire logic        sys_clk,      // System clock
  input  wire logic        resetn,       // Reset, low
  input  wire logic        intRequest,   // Offer from the controller
  input  wire logic [15:0] intVector,    // Vector of the offer
  input  wire logic [3:0]  acceptDelay,  // Cycles to stall before taking
  output var  logic        intAccept,    // One-cycle take pulse
  output var  logic [15:0] takenVector,  // Vector of the last take
  output var  logic [7:0]  takenCount    // Number of takes so far
);
  logic [3:0] waitCnt;  // Cycles the current offer has waited

  initial begin
    intAccept = 1'b0;
    takenVector = 16'h0000;
    takenCount = 8'h00;
    waitCnt = 4'h0;
  end

  // Drive on the falling edge so the controller samples a settled pulse
  always @(negedge sys_clk) begin
    if (!resetn) begin
      intAccept <= 1'b0;
      waitCnt <= 4'h0;
    end else if (intAccept) begin
      // One pulse only; the controller drops its offer on that edge
      intAccept <= 1'b0;
      waitCnt <= 4'h0;
    end else if (intRequest) begin
      if (waitCnt >= acceptDelay) begin
        intAccept <= 1'b1;
        takenVector <= intVector;
        takenCount <= takenCount + 8'h01;
      end else begin
        waitCnt <= waitCnt + 4'h1;  // Slow core: offer must stand
      end
    end else begin
      waitCnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_prioritized_interrupt_latch_controller.sv ----
// Self-checking bench for the interrupt latch controller
`timescale 1ns/100ps
`default_nettype none
`include "pilc_regs.svh"
module tb_prioritized_interrupt_latch_controller;
  logic        sys_clk;      // 10 MHz clock
  logic        resetn;       // Reset, low
  logic [7:0]  regAddr;      // Register address
  logic [7:0]  regWriteData; // Store data
  logic        regWrite;     // Store strobe
  logic [7:0]  regReadData;  // Load data
  logic [19:0] evts;         // Event pulses, bit 19 is the return
  logic        lineZeroEnable;
  logic        trapActionChoice;
  logic        watchdogActionChoice;
  logic        intRequest;
  logic [15:0] intVector;
  logic        intAccept;
  logic        stackedMaster;
  logic [3:0]  acceptDelay;  // Core stall length
  logic [15:0] takenVector;
  logic [7:0]  takenCount;
  logic [7:0]  rd;           // Last value read
  int          n_errors;
  int          n_checks;
  logic [15:0] vt [4] = '{16'hFFFC, 16'hFFFC, 16'hFFFA, 16'hFFF8};

  pilc_controller pilc_controller_inst (
    .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite),
    .regReadData(regReadData), .softwareTrap(evts[0]),
    .badOpcodeEvent(evts[1]), .fetchTrapEvent(evts[2]),
    .watchdogEvent(evts[3]), .extLineZero(evts[4]),
    .plainEvents(evts[12:5]), .uartReceiveEvent(evts[13]),
    .timer2Event(evts[14]), .extLineFour(evts[15]),
    .uartTransmitEvent(evts[16]), .extLineFive(evts[17]),
    .converterDoneEvent(evts[18]), .lineZeroEnable(lineZeroEnable),
    .trapActionChoice(trapActionChoice),
    .watchdogActionChoice(watchdogActionChoice),
    .intRequest(intRequest), .intVector(intVector),
    .intAccept(intAccept), .returnFromHandler(evts[19]),
    .stackedMaster(stackedMaster));

  pilc_core_model pilc_core_model_inst (
    .sys_clk(sys_clk), .resetn(resetn), .intRequest(intRequest),
    .intVector(intVector), .acceptDelay(acceptDelay),
    .intAccept(intAccept), .takenVector(takenVector),
    .takenCount(takenCount));

  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compare a register byte
  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare a vector address
  task automatic chkVec(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Plain store: strobe for one cycle, idle cycle between stores
  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
  endtask

  // Load: data is registered one edge after the address
  task automatic regRd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    regAddr = a;
    @(negedge sys_clk);
    chkReg(regReadData, exp);
  endtask

  // One-cycle pulse on a set of event inputs
  task automatic fire(input logic [19:0] m);
    @(negedge sys_clk);
    evts = m;
    @(negedge sys_clk);
    evts = 20'h00000;
  endtask

  // Bounded wait for the core to take an offer, then check its vector
  task automatic expectTake(input logic [15:0] exp);
    logic [7:0] start;
    int i;
    start = takenCount;
    // Count moves on a falling edge, so look for it on rising edges
    for (i = 0; i < 40 && takenCount == start; i++) @(posedge sys_clk);
    // Let the accept edge pass so the stacked state has settled
    @(negedge sys_clk);
    if (takenCount == start) begin
      n_errors++;
      final_report();
    end else begin
      chkVec(takenVector, exp);
    end
  endtask

  // Reset held three cycles, then settle past the two-flop release
  task automatic doReset();
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    chkReg({7'h00, intRequest}, 8'h00);
    resetn = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  // Quiet period in which no offer may appear
  task automatic noOffer();
    repeat (5) @(negedge sys_clk);
    chkReg({7'h00, intRequest}, 8'h00);
  endtask

  initial begin
    resetn = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    regWrite = 1'b0;
    evts = 20'h00000;
    lineZeroEnable = 1'b0;
    trapActionChoice = 1'b1;   // Reset request, as after reset
    watchdogActionChoice = 1'b1;
    acceptDelay = 4'h0;
    n_errors = 0;
    n_checks = 0;
    doReset();
    // Reset values and an unmapped place
    regRd(`PILC_ADDR_ENABLE_LOW, 8'h00);
    regRd(`PILC_ADDR_LATCH_LOW, 8'h00);
    regRd(`PILC_ADDR_LATCH_HIGH, 8'h00);
    regRd(`PILC_ADDR_SELECTOR, 8'h00);
    regWr(8'h40, 8'hFF);
    regRd(8'h40, 8'h00);
    // Unselected shared sources are dropped
    fire(20'h54000);
    regRd(`PILC_ADDR_LATCH_HIGH, 8'h00);
    // Ones stored into clear latches must not set them
    regWr(`PILC_ADDR_LATCH_HIGH, 8'hFF);
    regRd(`PILC_ADDR_LATCH_HIGH, 8'h00);
    // Every latched maskable source, master off
    fire(20'h2BFF0);
    regRd(`PILC_ADDR_LATCH_LOW, 8'hF0);
    regRd(`PILC_ADDR_LATCH_HIGH, 8'hFF);
    chkReg({7'h00, intRequest}, 8'h00);
    regWr(`PILC_ADDR_LATCH_LOW, 8'hFF);
    regRd(`PILC_ADDR_LATCH_LOW, 8'hF0);
    regWr(`PILC_ADDR_LATCH_LOW, 8'hEF);
    regRd(`PILC_ADDR_LATCH_LOW, 8'hE0);
    regWr(`PILC_ADDR_LATCH_HIGH, 8'h00);
    regWr(`PILC_ADDR_LATCH_LOW, 8'h0C);
    regRd(`PILC_ADDR_LATCH_HIGH, 8'h00);
    regRd(`PILC_ADDR_LATCH_LOW, 8'h00);
    // Trap and watchdog as reset requests raise nothing
    fire(20'h0000C);
    noOffer();
    regRd(`PILC_ADDR_LATCH_LOW, 8'h00);
    trapActionChoice = 1'b0;
    watchdogActionChoice = 1'b0;
    // Non-maskables taken with every enable off
    for (int i = 0; i < 4; i++) begin
      fire(20'h00001 << i);
      expectTake(vt[i]);
    end
    regRd(`PILC_ADDR_LATCH_LOW, 8'h00);
    // Master set last, after the enables
    regWr(`PILC_ADDR_ENABLE_HIGH, 8'hFF);
    regWr(`PILC_ADDR_ENABLE_LOW, 8'hF0);
    regRd(`PILC_ADDR_ENABLE_LOW, 8'hF0);
    regWr(`PILC_ADDR_ENABLE_LOW, 8'hF1);
    acceptDelay = 4'h4;
    // Latches 4, 5, 12 together; line zero pin function off
    fire(20'h01030);
    expectTake(16'hFFF4);
    chkReg({7'h00, stackedMaster}, 8'h01);
    regRd(`PILC_ADDR_ENABLE_LOW, 8'hF0);
    noOffer();
    lineZeroEnable = 1'b1;
    fire(20'h80000);
    regRd(`PILC_ADDR_ENABLE_LOW, 8'hF1);
    expectTake(16'hFFF6);
    fire(20'h80000);
    expectTake(16'hFFE6);
    regRd(`PILC_ADDR_LATCH_LOW, 8'h00);
    regRd(`PILC_ADDR_LATCH_HIGH, 8'h00);
    // Alternate sources of the shared levels
    acceptDelay = 4'h0;
    regWr(`PILC_ADDR_SELECTOR, 8'h07);
    regRd(`PILC_ADDR_SELECTOR, 8'h07);
    fire(20'h54000);
    for (int i = 0; i < 3; i++) begin
      fire(20'h80000);
      expectTake(16'hFFE4 - 16'(2 * i));
    end
    // Own enable off holds latch 8 back
    regWr(`PILC_ADDR_ENABLE_HIGH, 8'hFE);
    fire(20'h00100);
    fire(20'h80000);
    noOffer();
    regRd(`PILC_ADDR_LATCH_HIGH, 8'h01);
    regWr(`PILC_ADDR_ENABLE_LOW, 8'hF0);
    regWr(`PILC_ADDR_ENABLE_HIGH, 8'hFF);
    regWr(`PILC_ADDR_ENABLE_LOW, 8'hF1);
    expectTake(16'hFFEE);
    // Second reset with a latch pending
    fire(20'h00020);
    doReset();
    regRd(`PILC_ADDR_LATCH_LOW, 8'h00);
    regRd(`PILC_ADDR_ENABLE_LOW, 8'h00);
    regRd(`PILC_ADDR_SELECTOR, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
